// file: bench/gate_drive_sequencer_bench.sv
// self-checking bench for the gate drive sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
	$display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module gate_drive_sequencer_bench;
	import gds_pkg::*;
	localparam int FALL_DLY = 3;
	localparam int GAP = FALL_DLY + NOV_CYC;
	logic clk, rst_n, enable, zero_current_enable_n, supply, snz;
	logic hs_below, ls_below, avs_read, avs_write, avs_waitrequest;
	logic high_side_gate, low_side_gate, irq, hs_d, ls_d;
	logic [1:0] pwm_code;
	logic [7:0] die_temp;
	logic [ADDR_W-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [6:0] row;
	// rows: enable, code, detect enable, comparator, expected high gate, low gate
	logic [6:0] rows [8] = '{7'h7A, 7'h4D, 7'h58, 7'h72, 7'h68, 7'h41, 7'h50, 7'h38};
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	int t_hs = 0;
	int t_ls = 0;
	int n;

	gds_top i_gds_top (.clk(clk), .rst_n(rst_n), .pwm_code(pwm_code), .enable(enable),
		.zero_current_enable_n(zero_current_enable_n), .supply_above_undervoltage_lockout(supply),
		.high_gate_below_1v(hs_below), .low_gate_below_1v(ls_below),
		.switch_node_zero(snz), .die_temp(die_temp), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.high_side_gate(high_side_gate), .low_side_gate(low_side_gate), .irq(irq));

	gds_far_model #(.FALL_DLY(FALL_DLY)) i_gds_far_model (.clk(clk), .rst_n(rst_n),
		.high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
		.high_gate_below_1v(hs_below), .low_gate_below_1v(ls_below));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic finish_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test

	// one Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
		if (k >= 50) failures++;
	endtask : bus

	task automatic cycles(input int c);
		repeat (c) @(posedge clk);
	endtask : cycles

	// gates never overlap, and the rising gate waits out sense delay plus dead time
	always @(posedge clk) begin
		cyc++;
		if (rst_n) begin
			`CHK(high_side_gate & low_side_gate, 1'b0)
			if (hs_d && !high_side_gate) t_hs = cyc;
			if (ls_d && !low_side_gate) t_ls = cyc;
			if (!ls_d && low_side_gate && t_hs > 0) `CHK(cyc - t_hs > GAP, 1'b1)
			if (!hs_d && high_side_gate && t_ls > 0) `CHK(cyc - t_ls > GAP, 1'b1)
		end
		hs_d = high_side_gate;
		ls_d = low_side_gate;
	end

	// watchdog sized well above the roughly 3500 cycles the sequence needs
	initial begin
		cycles(20000);
		failures++;
		finish_test();
	end

	initial begin
		rst_n = 1'b0;
		pwm_code = PWM_CODE_HIGH;
		enable = 1'b1;
		zero_current_enable_n = 1'b1;
		supply = 1'b1;
		snz = 1'b0;
		die_temp = 8'h19;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		cycles(8);
		`CHK({high_side_gate, low_side_gate, irq, avs_waitrequest}, 4'h1)
		rst_n <= 1'b1;
		// supply already high at release: calibration holds gates low
		cycles(700);
		`CHK({high_side_gate, low_side_gate}, 2'h0)
		bus(1'b0, REG_STATUS, '0);
		`CHK(rd[4], 1'b1)
		cycles(800);
		`CHK(high_side_gate, 1'b1)
		bus(1'b0, REG_CTRL, '0);
		`CHK(rd, 32'(CTRL_RESET))
		bus(1'b0, REG_MASK, '0);
		`CHK(rd, 32'(EV_RESET))
		bus(1'b0, 4'h2, '0);
		`CHK(rd, 32'h00000000)
		bus(1'b1, REG_EVENT, 32'h0000000F);
		bus(1'b0, REG_EVENT, '0);
		`CHK(rd[EV_W-1:0], 4'h0)
		// logic table rows
		for (int i = 0; i < 8; i++) begin
			row = rows[i];
			enable <= row[6];
			pwm_code <= row[5:4];
			zero_current_enable_n <= row[3];
			snz <= row[2];
			cycles(30);
			`CHK({high_side_gate, low_side_gate}, row[1:0])
		end
		// zero-current trip, comparator already showing zero before the low side rises
		bus(1'b1, REG_MASK, 32'h00000002);
		enable <= 1'b1;
		pwm_code <= PWM_CODE_HIGH;
		zero_current_enable_n <= 1'b0;
		snz <= 1'b1;
		cycles(30);
		`CHK(irq, 1'b0)
		pwm_code <= PWM_CODE_LOW;
		n = 0;
		while (low_side_gate !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		// a low side that never rises is a failure, not a silent pass
		if (n >= 40) failures++;
		cycles(BLANK_CYC - 1);
		`CHK(low_side_gate, 1'b1)
		cycles(30);
		`CHK({low_side_gate, irq}, 2'h1)
		bus(1'b0, REG_EVENT, '0);
		`CHK(rd[EV_ZC_TRIP], 1'b1)
		bus(1'b1, REG_EVENT, 32'h0000000F);
		cycles(2);
		`CHK(irq, 1'b0)
		// thermal trip and release boundaries
		zero_current_enable_n <= 1'b1;
		snz <= 1'b0;
		pwm_code <= PWM_CODE_HIGH;
		die_temp <= 8'hA9;
		cycles(30);
		`CHK(high_side_gate, 1'b1)
		die_temp <= 8'hAA;
		cycles(20);
		`CHK(high_side_gate, 1'b0)
		die_temp <= 8'h97;
		cycles(20);
		`CHK(high_side_gate, 1'b0)
		die_temp <= 8'h96;
		cycles(30);
		`CHK(high_side_gate, 1'b1)
		// supply dip, then a fresh calibration on the rise
		supply <= 1'b0;
		cycles(20);
		`CHK(high_side_gate, 1'b0)
		supply <= 1'b1;
		cycles(700);
		`CHK({high_side_gate, low_side_gate}, 2'h0)
		cycles(800);
		`CHK(high_side_gate, 1'b1)
		// reset in mid-run: outputs drop at once, calibration starts afresh
		rst_n <= 1'b0;
		cycles(3);
		`CHK({high_side_gate, low_side_gate, irq, avs_waitrequest}, 4'h1)
		rst_n <= 1'b1;
		cycles(40);
		`CHK({high_side_gate, low_side_gate}, 2'h0)
		finish_test();
	end
endmodule : gate_drive_sequencer_bench
`default_nettype wire

// file: bench/gds_far_model.sv
// far-side model: gate voltage sense comparators behind the two drivers
`timescale 1ns/100ps
`default_nettype none
module gds_far_model #(
	parameter int FALL_DLY = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic high_side_gate,
	input wire logic low_side_gate,
	output logic high_gate_below_1v,
	output logic low_gate_below_1v
);
	int hs_cnt;
	int ls_cnt;
	// a gate drains slowly, so sense reports below 1 V only after the fall delay
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hs_cnt <= FALL_DLY;
			ls_cnt <= FALL_DLY;
		end else begin
			hs_cnt <= high_side_gate ? 0 : ((hs_cnt < FALL_DLY) ? hs_cnt + 1 : hs_cnt);
			ls_cnt <= low_side_gate ? 0 : ((ls_cnt < FALL_DLY) ? ls_cnt + 1 : ls_cnt);
		end
	end
	// sense drops on the first clock after a gate is driven, no stale low reading after that
	assign high_gate_below_1v = (hs_cnt >= FALL_DLY);
	assign low_gate_below_1v = (ls_cnt >= FALL_DLY);
endmodule : gds_far_model
`default_nettype wire

// file: pkg/gds_pkg.sv
// constants, types and helpers shared by the gate drive sequencer
package gds_pkg;
	// core clock
	localparam int CLK_NS = 20;
	// timing figures in their own units, then in clock cycles
	localparam int BLANK_NS = 130;
	localparam int NOV_NS = 40;
	localparam int CAL_NS = 28000;
	localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int NOV_CYC = (NOV_NS + CLK_NS - 1) / CLK_NS;
	localparam int CAL_CYC = (CAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 11;
	localparam logic [CNT_W-1:0] BLANK_CNT = CNT_W'(BLANK_CYC);
	localparam logic [CNT_W-1:0] NOV_CNT = CNT_W'(NOV_CYC - 1);
	localparam logic [CNT_W-1:0] CAL_CNT = CNT_W'(CAL_CYC);
	// die temperature thresholds in degrees C
	localparam int TRIP_C = 170;
	localparam int HYS_C = 20;
	localparam logic [7:0] TEMP_TRIP = 8'(TRIP_C);
	localparam logic [7:0] TEMP_RELEASE = 8'(TRIP_C - HYS_C);
	// comparator codes of the three-level input
	localparam logic [1:0] PWM_CODE_LOW = 2'h0;
	localparam logic [1:0] PWM_CODE_MID = 2'h1;
	localparam logic [1:0] PWM_CODE_HIGH = 2'h3;
	// register map, byte addresses
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_EVENT = 4'h8;
	localparam logic [ADDR_W-1:0] REG_MASK = 4'hC;
	// control fields
	localparam int CTRL_W = 2;
	localparam int CTRL_THERM_EN = 0;
	localparam int CTRL_FORCE_OFF = 1;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h1;
	// event fields, shared by event and mask registers
	localparam int EV_W = 4;
	localparam int EV_THERMAL = 0;
	localparam int EV_ZC_TRIP = 1;
	localparam int EV_CAL_DONE = 2;
	localparam int EV_UNDERVOLT = 3;
	localparam logic [EV_W-1:0] EV_RESET = 4'h0;

	typedef enum logic [1:0] {
		LVL_LOW = 2'b00,
		LVL_MID = 2'b01,
		LVL_HIGH = 2'b10
	} gds_level_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_HS_ON = 3'b001,
		S_HS_OFF_WAIT = 3'b010,
		S_NOV = 3'b011,
		S_LS_ON = 3'b100,
		S_LS_OFF_WAIT = 3'b101
	} gds_state_t;

	// asynchronous pin inputs travel together through the synchroniser
	typedef struct packed {
		logic [1:0] pwm_code;
		logic enable;
		logic zero_current_enable_n;
		logic supply_ok;
		logic hs_below_1v;
		logic ls_below_1v;
		logic switch_node_zero;
		logic [7:0] die_temp;
	} gds_pins_t;

	// safe values: mid level, disabled, detection off, gates sensed low
	localparam gds_pins_t PINS_RESET = '{pwm_code: 2'h1, enable: 1'b0,
		zero_current_enable_n: 1'b1, supply_ok: 1'b0, hs_below_1v: 1'b1,
		ls_below_1v: 1'b1, switch_node_zero: 1'b0, die_temp: 8'h00};

	// unknown comparator code counts as the middle level
	function automatic gds_level_t decode_level(input logic [1:0] code);
		gds_level_t lvl;
		lvl = LVL_MID;
		if (code == PWM_CODE_LOW) begin
			lvl = LVL_LOW;
		end else if (code == PWM_CODE_HIGH) begin
			lvl = LVL_HIGH;
		end
		return lvl;
	endfunction : decode_level
endpackage : gds_pkg

// file: rtl/gds_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module gds_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] ff1_q;
	logic [W-1:0] ff2_q;
	logic [W-1:0] ff3_q;
	logic [W-1:0] agree;

	// ff1 feeds ff2 only, the filter looks at ff2 and ff3
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ff1_q <= RST_VAL;
			ff2_q <= RST_VAL;
			ff3_q <= RST_VAL;
		end else begin
			ff1_q <= d;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
		end
	end

	assign agree = ~(ff2_q ^ ff3_q);

	// a bit only moves once two stages agree, so one-cycle glitches die here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RST_VAL;
		end else begin
			q <= (ff3_q & agree) | (q & ~agree);
		end
	end
endmodule : gds_sync
`default_nettype wire

// file: rtl/gds_top.sv
// gate drive sequencer: input decode, dead time, zero-current cut-off, faults, registers
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`default_nettype none
module gds_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] pwm_code,
	input wire logic enable,
	input wire logic zero_current_enable_n,
	input wire logic supply_above_undervoltage_lockout,
	input wire logic high_gate_below_1v,
	input wire logic low_gate_below_1v,
	input wire logic switch_node_zero,
	input wire logic [7:0] die_temp,
	input wire logic [gds_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic high_side_gate,
	output logic low_side_gate,
	output logic irq
);
	import gds_pkg::*;

	logic rst_meta_q;
	logic rst_sync_q;
	gds_pins_t pins_raw;
	gds_pins_t pins_s;
	gds_level_t level;
	gds_state_t state_q;
	gds_state_t state_d;
	logic [CNT_W-1:0] cal_q;
	logic [CNT_W-1:0] nov_q;
	logic [CNT_W-1:0] blank_q;
	logic supply_prev_q;
	logic therm_fault_q;
	logic ls_block_q;
	logic [CTRL_W-1:0] ctrl_q;
	logic [EV_W-1:0] ev_q;
	logic [EV_W-1:0] ev_d;
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] mask_q;
	logic [EV_W-1:0] mask_d;
	logic [31:0] rd_mux;
	logic cal_busy;
	logic allowed;
	logic zc_active;
	logic zc_trip;
	logic want_hs;
	logic want_ls;
	logic therm_set;
	logic wr_en;

	// reset enters asynchronously but is released on the clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// every pin comes from outside the clock domain
	assign pins_raw = '{pwm_code: pwm_code, enable: enable,
		zero_current_enable_n: zero_current_enable_n, supply_ok: supply_above_undervoltage_lockout,
		hs_below_1v: high_gate_below_1v, ls_below_1v: low_gate_below_1v,
		switch_node_zero: switch_node_zero, die_temp: die_temp};

	// detection enable resets high so it starts out disabled
	gds_sync #(
		.W($bits(gds_pins_t)),
		.RST_VAL(PINS_RESET)
	) u_sync (
		.clk(clk),
		.rst_n(rst_sync_q),
		.d(pins_raw),
		.q(pins_s)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_q);

	assign level = decode_level(pins_s.pwm_code);

	// calibration restarts on every supply rise; the pin level is ignored meanwhile
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			supply_prev_q <= 1'b0;
			cal_q <= '0;
		end else begin
			supply_prev_q <= pins_s.supply_ok;
			if (pins_s.supply_ok && !supply_prev_q) begin
				cal_q <= CAL_CNT;
			end else if (cal_q != '0) begin
				cal_q <= cal_q - CNT_W'(1);
			end
		end
	end
	assign cal_busy = (cal_q != '0);

	cal_holds_off_a: assert property (cal_busy |=> !high_side_gate && !low_side_gate)
		else $error("gate on during calibration");
	cal_length_a: assert property ($rose(pins_s.supply_ok) |=> cal_busy [*8])
		else $error("calibration ended too early");

	// hysteresis keeps the fault from chattering around the trip point
	assign therm_set = (pins_s.die_temp >= TEMP_TRIP);
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			therm_fault_q <= 1'b0;
		end else if (!ctrl_q[CTRL_THERM_EN]) begin
			therm_fault_q <= 1'b0;
		end else if (therm_set) begin
			therm_fault_q <= 1'b1;
		end else if (pins_s.die_temp <= TEMP_RELEASE) begin
			therm_fault_q <= 1'b0;
		end
	end

	thermal_trip_a: assert property (ctrl_q[CTRL_THERM_EN] && therm_set |=> therm_fault_q)
		else $error("thermal trip not taken");
	thermal_hold_a: assert property (therm_fault_q |=> !high_side_gate && !low_side_gate)
		else $error("gate on during thermal fault");

	// overall permission to switch
	assign allowed = pins_s.supply_ok && pins_s.enable && !cal_busy && !therm_fault_q
		&& !ctrl_q[CTRL_FORCE_OFF];

	// comparator looked at only in low-side conduction, after blanking
	assign zc_active = !pins_s.zero_current_enable_n;
	assign zc_trip = zc_active && (state_q == S_LS_ON) && (blank_q == '0)
		&& pins_s.switch_node_zero;

	// a trip blocks the low side until the input leaves its low level
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ls_block_q <= 1'b0;
		end else if (level != LVL_LOW) begin
			ls_block_q <= 1'b0;
		end else if (zc_trip) begin
			ls_block_q <= 1'b1;
		end
	end

	assign want_hs = allowed && (level == LVL_HIGH);
	assign want_ls = allowed && (level == LVL_LOW) && !ls_block_q && !zc_trip;

	// sequencer: every hand-over passes gate-low sensing and the dead timer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: begin
				if (want_hs && pins_s.ls_below_1v) begin
					state_d = S_HS_ON;
				end else if (want_ls && pins_s.hs_below_1v) begin
					state_d = S_LS_ON;
				end
			end
			S_HS_ON: begin
				if (!want_hs) begin
					state_d = S_HS_OFF_WAIT;
				end
			end
			S_HS_OFF_WAIT: begin
				if (pins_s.hs_below_1v) begin
					state_d = S_NOV;
				end
			end
			S_NOV: begin
				if (nov_q == '0) begin
					state_d = S_IDLE;
				end
			end
			S_LS_ON: begin
				if (!want_ls) begin
					state_d = S_LS_OFF_WAIT;
				end
			end
			S_LS_OFF_WAIT: begin
				if (pins_s.ls_below_1v) begin
					state_d = S_NOV;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// gate commands follow the next state, so they change with it
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			high_side_gate <= 1'b0;
			low_side_gate <= 1'b0;
		end else begin
			high_side_gate <= (state_d == S_HS_ON);
			low_side_gate <= (state_d == S_LS_ON);
		end
	end

	// dead timer and blanking counter, both in core cycles
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			nov_q <= '0;
			blank_q <= '0;
		end else begin
			if (state_d == S_NOV && state_q != S_NOV) begin
				nov_q <= NOV_CNT;
			end else if (nov_q != '0) begin
				nov_q <= nov_q - CNT_W'(1);
			end
			if (state_d == S_LS_ON && state_q != S_LS_ON) begin
				blank_q <= BLANK_CNT;
			end else if (blank_q != '0) begin
				blank_q <= blank_q - CNT_W'(1);
			end
		end
	end

	sequence hs_release_s;
		$fell(high_side_gate);
	endsequence
	sequence ls_release_s;
		$fell(low_side_gate);
	endsequence
	sequence ls_rise_s;
		$rose(low_side_gate);
	endsequence
	property dead_time_p(start, other);
		start |-> !other [*4];
	endproperty

	gate_overlap_a: assert property (!(high_side_gate && low_side_gate))
		else $error("both gates on");
	hs_to_ls_dead_a: assert property (dead_time_p(hs_release_s, low_side_gate))
		else $error("low side rose inside dead time");
	ls_to_hs_dead_a: assert property (dead_time_p(ls_release_s, high_side_gate))
		else $error("high side rose inside dead time");
	nov_after_sense_a: assert property (state_q == S_NOV && $past(state_q) == S_HS_OFF_WAIT
		|-> $past(pins_s.hs_below_1v))
		else $error("dead timer started before gate below 1 V");
	blank_window_a: assert property (ls_rise_s |-> !zc_trip [*7])
		else $error("comparator used during blanking");
	zc_cut_off_a: assert property (zc_trip |=> !low_side_gate [*2])
		else $error("low side stayed on after trip");
	zc_disabled_a: assert property (pins_s.zero_current_enable_n |-> !zc_trip)
		else $error("trip while detection disabled");
	zc_only_ls_a: assert property (zc_trip |-> low_side_gate)
		else $error("trip outside low-side conduction");
	not_allowed_a: assert property (!allowed |=> !high_side_gate && !low_side_gate)
		else $error("gate on while switching not allowed");
	mid_level_a: assert property (level == LVL_MID |=> !high_side_gate && !low_side_gate)
		else $error("gate on at middle level");
	low_level_hs_a: assert property (level == LVL_LOW |=> !high_side_gate)
		else $error("high side on at low level");
	hs_start_a: assert property (state_q == S_IDLE && want_hs && pins_s.ls_below_1v
		|=> high_side_gate && !low_side_gate)
		else $error("high side not started");
	ls_start_a: assert property (state_q == S_IDLE && allowed && level == LVL_LOW
		&& pins_s.zero_current_enable_n && !ls_block_q && pins_s.hs_below_1v
		|=> low_side_gate && !high_side_gate)
		else $error("low side not started");

	// bus slave: one wait cycle, then a single ready cycle
	assign wr_en = avs_write && !avs_waitrequest;
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// read mux; unmapped addresses read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address)
			REG_CTRL: rd_mux = {30'h0, ctrl_q};
			REG_STATUS: rd_mux = {22'h0, low_side_gate, high_side_gate, level, allowed,
				cal_busy, therm_fault_q, state_q};
			REG_EVENT: rd_mux = {28'h0, ev_q};
			REG_MASK: rd_mux = {28'h0, mask_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// data are latched in the wait cycle and stand at the ready edge
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_mux;
		end
	end

	// control register steers thermal protection and a software hold-off
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_en && avs_address == REG_CTRL) begin
			ctrl_q <= avs_writedata[CTRL_W-1:0];
		end
	end

	// sticky events; a new event beats a write-one-to-clear in the same cycle
	always_comb begin
		ev_set = EV_RESET;
		ev_set[EV_THERMAL] = therm_set && ctrl_q[CTRL_THERM_EN] && !therm_fault_q;
		ev_set[EV_ZC_TRIP] = zc_trip;
		ev_set[EV_CAL_DONE] = (cal_q == CNT_W'(1));
		ev_set[EV_UNDERVOLT] = supply_prev_q && !pins_s.supply_ok;
		ev_d = ev_q;
		if (wr_en && avs_address == REG_EVENT) begin
			ev_d = ev_q & ~avs_writedata[EV_W-1:0];
		end
		ev_d = ev_d | ev_set;
		mask_d = mask_q;
		if (wr_en && avs_address == REG_MASK) begin
			mask_d = avs_writedata[EV_W-1:0];
		end
	end

	// interrupt is registered from the same next values as the bits it reflects
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ev_q <= EV_RESET;
			mask_q <= EV_RESET;
			irq <= 1'b0;
		end else begin
			ev_q <= ev_d;
			mask_q <= mask_d;
			irq <= |(ev_d & mask_d);
		end
	end

	irq_level_a: assert property (irq == |(ev_q & mask_q))
		else $error("interrupt disagrees with event bits");
	ev_sticky_a: assert property (ev_q[EV_ZC_TRIP] && !(wr_en && avs_address == REG_EVENT)
		|=> ev_q[EV_ZC_TRIP])
		else $error("event bit lost without clear");
endmodule : gds_top
`default_nettype wire
